// >>> motor_chop_pkg.sv
/*
 * Shared constants, types and helpers for the two-bridge current chopper:
 * register offsets, timing counts, state codes and gate patterns.
 * Assumes a 100 MHz core clock and a 32-bit APB register bus.
 */
package motor_chop_pkg;

	// Core clock and the times that the chopper is built from.
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ = 100_000_000;
	localparam int PWM_FREQ_HZ = 42_500;
	localparam int BLANK_LONG_NS = 2400;
	localparam int BLANK_SHORT_NS = 1600;
	localparam int WAKE_TIME_NS = 1_000_000;

	// Cycle counts; the period and wake time round down, blanking times round up.
	localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
	localparam logic [11:0] PWM_LAST = 12'(PWM_PERIOD_CYC - 1);
	localparam logic [11:0] BLANK_LONG_CYC =
		12'((BLANK_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] BLANK_SHORT_CYC =
		12'((BLANK_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int WAKE_CYC = WAKE_TIME_NS / CLK_PERIOD_NS;

	// Current scale codes: 31 is full scale, codes at or below the
	// low mark (about 29 percent) get the short blanking interval.
	localparam logic [4:0] DAC_FULL_CODE = 5'h1F;
	localparam logic [4:0] DAC_MIN_CODE = 5'h02;
	localparam logic [4:0] DAC_LOW_CODE_MAX = 5'h08;
	localparam logic [2:0] DECAY_ALL_FAST = 3'h4;

	// Register byte offsets and reset values.
	localparam logic [7:0] DRIVE_CTRL_OFFSET = 8'h00;
	localparam logic [7:0] CURRENT_CODE_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [5:0] DRIVE_CTRL_RESET = 6'h00;
	localparam logic [4:0] CURRENT_CODE_RESET = 5'h1F;

	typedef enum logic [4:0] {
		ST_OFF   = 5'b00001,
		ST_DRIVE = 5'b00010,
		ST_FAST  = 5'b00100,
		ST_SLOW  = 5'b01000,
		ST_IDLE  = 5'b10000
	} chop_state_t;

	typedef struct packed {
		logic hs1;
		logic ls1;
		logic hs2;
		logic ls2;
	} bridge_gate_t;

	typedef struct packed {
		logic       on;
		logic       dir;
		logic       brake;
		logic       forceSlow;
		logic       shortBlank;
		logic [2:0] level;
	} chop_cmd_t;

	// Length of the fast-decay share for a decay level of 0 to 4.
	function automatic logic [11:0] fast_cycles(input logic [2:0] level);
		fast_cycles = 12'((PWM_PERIOD_CYC * int'(level)) / 4);
	endfunction

	// Gate pattern for a chopper state; dir high drives out1 positive.
	function automatic bridge_gate_t gate_of(input chop_state_t st,
		input logic dir, input logic brake);
		gate_of = '{hs1: 1'b0, ls1: 1'b0, hs2: 1'b0, ls2: 1'b0};
		case (st)
			ST_DRIVE: gate_of = '{hs1: dir, ls1: !dir, hs2: !dir, ls2: dir};
			ST_FAST:  gate_of = '{hs1: !dir, ls1: dir, hs2: dir, ls2: !dir};
			ST_SLOW:  gate_of = '{hs1: 1'b0, ls1: 1'b1, hs2: 1'b0, ls2: 1'b1};
			ST_OFF:   gate_of = '{hs1: 1'b0, ls1: brake, hs2: 1'b0, ls2: brake};
			default:  gate_of = '{hs1: 1'b0, ls1: 1'b0, hs2: 1'b0, ls2: 1'b0};
		endcase
	endfunction

endpackage

// >>> input_sync.sv
/*
 * Two-flop synchroniser for a vector of slow pin levels.
 * Assumes each bit is a level that stays put far longer than a clock;
 * multi-bit fields are only coherent once they have been stable.
 */
`timescale 1ns/1ps
module input_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] pinLevel,
	output logic      [WIDTH-1:0] syncLevel
);
	logic [WIDTH-1:0] firstStage;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			firstStage <= '0;
			syncLevel <= '0;
		end else begin
			firstStage <= pinLevel;
			syncLevel <= firstStage;
		end
	end
endmodule // input_sync

// >>> bridge_chopper.sv
/*
 * Current chopper for one H-bridge: drive, blanking, trip, then fast,
 * slow or mixed decay until the next PWM period starts.
 * Assumes synchronised comparator inputs and a shared period pulse.
 */
`timescale 1ns/1ps
module bridge_chopper
	import motor_chop_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         pwmStart,
	input  wire chop_cmd_t    cmd,
	input  wire logic         trip,
	input  wire logic         zeroCurrent,
	output chop_state_t       state,
	output bridge_gate_t      gates
);
	chop_state_t next_state;
	logic [11:0] timer;
	wire  [11:0] blankCyc = cmd.shortBlank ? BLANK_SHORT_CYC : BLANK_LONG_CYC;
	wire  [11:0] fastCyc = fast_cycles(cmd.level);
	wire         blanked = timer < blankCyc;
	wire         slowFirst = cmd.forceSlow || (cmd.level == 3'h0);
	wire         fastDone = (cmd.level < DECAY_ALL_FAST) &&
		(timer >= fastCyc - 12'h001);

	// Next state; a new period restarts the drive phase unless the bridge is off.
	always_comb begin
		next_state = state;
		if (!cmd.on) begin
			next_state = ST_OFF;
		end else if (pwmStart) begin
			next_state = ST_DRIVE;
		end else begin
			case (state)
				ST_DRIVE: begin
					if (!blanked && trip) begin
						next_state = slowFirst ? ST_SLOW : ST_FAST;
					end
				end
				ST_FAST: begin
					if (zeroCurrent) begin
						next_state = ST_IDLE;
					end else if (fastDone) begin
						next_state = ST_SLOW;
					end
				end
				default: next_state = state;
			endcase
		end
	end

	// The timer restarts on every state change, so it measures the
	// blanking interval in drive and the fast share after a trip.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_OFF;
			timer <= 12'h000;
			gates <= '{hs1: 1'b0, ls1: 1'b0, hs2: 1'b0, ls2: 1'b0};
		end else begin
			state <= next_state;
			timer <= (next_state != state || pwmStart) ? 12'h000 :
				timer + 12'(timer != 12'hFFF);
			gates <= gate_of(next_state, cmd.dir, cmd.brake);
		end
	end

	property p_blankHold;
		@(posedge clk) disable iff (!rst_b)
		(state == ST_DRIVE && blanked && cmd.on && !pwmStart)
			|=> state == ST_DRIVE;
	endproperty
	a_blankHold: assert property (p_blankHold)
		else $error("Trip acted during blanking.");

	property p_tripStops;
		@(posedge clk) disable iff (!rst_b)
		(state == ST_DRIVE && !blanked && trip && cmd.on && !pwmStart)
			|=> (state == ST_FAST || state == ST_SLOW) &&
			gates != gate_of(ST_DRIVE, $past(cmd.dir), 1'b0);
	endproperty
	a_tripStops: assert property (p_tripStops)
		else $error("Drive did not stop after a trip.");

	property p_fastReverse;
		@(posedge clk) disable iff (!rst_b)
		(state == ST_FAST && $past(cmd.dir)) |-> gates.hs2 && gates.ls1;
	endproperty
	a_fastReverse: assert property (p_fastReverse)
		else $error("Fast decay did not reverse the bridge.");

	property p_zeroStop;
		@(posedge clk) disable iff (!rst_b)
		(state == ST_FAST && zeroCurrent && cmd.on && !pwmStart)
			|=> state == ST_IDLE ##0 gates == 4'b0000;
	endproperty
	a_zeroStop: assert property (p_zeroStop)
		else $error("Bridge not off at zero current.");

	property p_slowLow;
		@(posedge clk) disable iff (!rst_b)
		state == ST_SLOW |-> gates == 4'b0101;
	endproperty
	a_slowLow: assert property (p_slowLow)
		else $error("Slow decay is not both low sides.");

	property p_mixedSwitch;
		@(posedge clk) disable iff (!rst_b)
		(state == ST_FAST && fastDone && !zeroCurrent && cmd.on && !pwmStart)
			|=> state == ST_SLOW;
	endproperty
	a_mixedSwitch: assert property (p_mixedSwitch)
		else $error("Mixed decay did not turn slow.");

	property p_forcedSlow;
		@(posedge clk) disable iff (!rst_b)
		(state == ST_DRIVE && !blanked && trip && cmd.forceSlow &&
			cmd.on && !pwmStart) |=> state == ST_SLOW;
	endproperty
	a_forcedSlow: assert property (p_forcedSlow)
		else $error("Rising current did not use slow decay.");

	property p_positiveDrive;
		@(posedge clk) disable iff (!rst_b)
		(state == ST_DRIVE && $past(cmd.dir)) |-> gates == 4'b1001;
	endproperty
	a_positiveDrive: assert property (p_positiveDrive)
		else $error("Direction one did not drive out1 high.");

	property p_offBrake;
		@(posedge clk) disable iff (!rst_b)
		(state == ST_OFF && $past(state) == ST_OFF) |->
			gates == ($past(cmd.brake) ? 4'b0101 : 4'b0000);
	endproperty
	a_offBrake: assert property (p_offBrake)
		else $error("Disabled bridge outputs are wrong.");
endmodule // bridge_chopper

// >>> motor_bridge_current_chopper.sv
/*
 * Control logic for two H-bridges with fixed-frequency current chopping,
 * control-scheme latch, wake timing and an APB register block.
 * Assumes comparators, zero-current detect and decay decoders outside,
 * delivering digital levels; step-table sequencing is done by software.
 */
// Contract
// - Scheme select high: indexer, else direction/enable.
// - Scheme latched at reset and sleep exit.
// - Undriven scheme select defaults to direction/enable.
// - Drive until trip, off until next period.
// - Ignore trip during blanking; sets minimum on-time.
// - Shorter blanking when commanded current is low.
// - Five-bit code per bridge scales reference.
// - Indexer trip scaled from five to hundred percent.
// - Full-scale trip at reference over five.
// - Fast decay reverses bridge, off near zero.
// - Slow decay turns both low sides on.
// - Mixed decay: fast, then slow for period.
// - Five decay levels: 0/25/50/75/100 percent fast.
// - Indexer uses bridge A decay select only.
// - Indexer forces slow decay while current rises.
// - Direction one is the positive drive direction.
// - PWM period fixed at 42.5 kHz.
// - Blanking: 2.4 us, 1.6 us below 29 percent.
// - Enable low: outputs off or braked by mode.
`timescale 1ns/1ps
module motor_bridge_current_chopper
	import motor_chop_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_CYC
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	input  wire logic         controlSchemeSelect,
	input  wire logic         sleep_request_n,
	input  wire logic [1:0]   bridge_direction,
	input  wire logic [1:0]   bridge_drive_enable,
	input  wire logic         step_mode_high_select,
	input  wire logic [1:0]   bridge_sense_input,
	input  wire logic [1:0]   zeroCurrentDetect,
	input  wire logic [2:0]   bridge_a_decay_select,
	input  wire logic [2:0]   bridge_b_decay_select,
	input  wire logic [1:0]   referenceLow,
	output logic [4:0]        bridgeAScale,
	output logic [4:0]        bridgeBScale,
	output bridge_gate_t      bridgeAGates,
	output bridge_gate_t      bridgeBGates,
	output logic              indexerMode,
	output logic              awake
);
	localparam int SYNC_W = 19;

	logic [SYNC_W-1:0] syncBus;
	logic        schemeSync;
	logic        sleepSync;
	logic [1:0]  dirSync;
	logic [1:0]  enableSync;
	logic        stepHighSync;
	logic [1:0]  tripSync;
	logic [1:0]  zeroSync;
	logic [2:0]  decayASync;
	logic [2:0]  decayBSync;
	logic [1:0]  refLowSync;

	logic        started;
	logic        sleepPrev;
	logic [11:0] pwmCount;
	logic [16:0] wakeCount;
	logic [5:0]  driveCtrl;
	logic [4:0]  codeA;
	logic [4:0]  codeB;
	chop_cmd_t   cmdA;
	chop_cmd_t   cmdB;
	chop_state_t stateA;
	chop_state_t stateB;

	// Every pin level passes two flops before logic sees it.
	input_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.pinLevel({controlSchemeSelect, sleep_request_n, bridge_direction,
			bridge_drive_enable, step_mode_high_select, bridge_sense_input,
			zeroCurrentDetect, bridge_a_decay_select, bridge_b_decay_select,
			referenceLow}),
		.syncLevel(syncBus)
	);

	// Named views of the synchronised pins.
	assign {schemeSync, sleepSync, dirSync, enableSync, stepHighSync,
		tripSync, zeroSync, decayASync, decayBSync, refLowSync} = syncBus;

	// The scheme is caught on the first cycle after reset and on each
	// rising edge of the sleep request; later changes are ignored.
	wire sleepExit = sleepSync && !sleepPrev;
	wire latchNow = !started || sleepExit;

	// Decay levels above four clamp to all fast.
	function automatic logic [2:0] clamp_level(input logic [2:0] lvl);
		clamp_level = (lvl > DECAY_ALL_FAST) ? DECAY_ALL_FAST : lvl;
	endfunction

	// Scale code for the trip reference; indexer codes never fall below
	// the five percent floor, the other scheme always uses full scale.
	function automatic logic [4:0] scale_of(input logic idx,
		input logic [4:0] code);
		scale_of = !idx ? DAC_FULL_CODE :
			(code < DAC_MIN_CODE ? DAC_MIN_CODE : code);
	endfunction

	// Scheme latch and sleep edge tracking. Reset leaves the scheme low,
	// the same choice an open pin with its pull-down gives.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			started <= 1'b0;
			sleepPrev <= 1'b0;
			indexerMode <= 1'b0;
		end else begin
			started <= 1'b1;
			sleepPrev <= sleepSync;
			if (latchNow) begin
				indexerMode <= schemeSync;
			end
		end
	end

	// Wake timer: the host must not step before it runs out; it only
	// reports here, since step pulses are sequenced by software.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wakeCount <= 17'h00000;
		end else if (!sleepSync) begin
			wakeCount <= 17'h00000;
		end else if (wakeCount != 17'(WAKE_CYCLES)) begin
			wakeCount <= wakeCount + 17'h00001;
		end
	end
	assign awake = wakeCount == 17'(WAKE_CYCLES);

	// Free-running PWM period counter shared by both bridges.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pwmCount <= 12'h000;
		end else begin
			pwmCount <= (pwmCount == PWM_LAST) ? 12'h000 : pwmCount + 12'h001;
		end
	end
	wire pwmStart = pwmCount == 12'h000;

	// Per-bridge commands. In indexer mode software supplies direction,
	// enable and the rising-current flags; bridge A decay rules both.
	assign cmdA.on = sleepSync &&
		(indexerMode ? driveCtrl[2] : enableSync[0]);
	assign cmdB.on = sleepSync &&
		(indexerMode ? driveCtrl[3] : enableSync[1]);
	assign cmdA.dir = indexerMode ? driveCtrl[0] : dirSync[0];
	assign cmdB.dir = indexerMode ? driveCtrl[1] : dirSync[1];
	// Sleep releases the brake as well, so a sleeping bridge floats.
	assign cmdA.brake = sleepSync && !indexerMode && !stepHighSync;
	assign cmdB.brake = sleepSync && !indexerMode && !stepHighSync;
	assign cmdA.forceSlow = indexerMode && driveCtrl[4];
	assign cmdB.forceSlow = indexerMode && driveCtrl[5];
	assign cmdA.level = clamp_level(decayASync);
	assign cmdB.level = clamp_level(indexerMode ? decayASync
		: decayBSync);
	// Short blanking for low commanded current.
	assign cmdA.shortBlank = indexerMode ? (codeA <= DAC_LOW_CODE_MAX)
		: refLowSync[0];
	assign cmdB.shortBlank = indexerMode ? (codeB <= DAC_LOW_CODE_MAX)
		: refLowSync[1];

	bridge_chopper u_chopA (
		.clk(clk),
		.rst_b(rst_b),
		.pwmStart(pwmStart),
		.cmd(cmdA),
		.trip(tripSync[0]),
		.zeroCurrent(zeroSync[0]),
		.state(stateA),
		.gates(bridgeAGates)
	);

	bridge_chopper u_chopB (
		.clk(clk),
		.rst_b(rst_b),
		.pwmStart(pwmStart),
		.cmd(cmdB),
		.trip(tripSync[1]),
		.zeroCurrent(zeroSync[1]),
		.state(stateB),
		.gates(bridgeBGates)
	);

	// Reference scale codes for the external trip comparators; the
	// comparator trips at the scaled reference over the gain of five,
	// which is analogue and sits outside this logic.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bridgeAScale <= DAC_FULL_CODE;
			bridgeBScale <= DAC_FULL_CODE;
		end else begin
			bridgeAScale <= scale_of(indexerMode, codeA);
			bridgeBScale <= scale_of(indexerMode, codeB);
		end
	end

	// APB decode; every access completes with no wait state.
	wire setupPhase = psel && !penable;
	wire accessPhase = psel && penable;
	wire hitCtrl = paddr == DRIVE_CTRL_OFFSET;
	wire hitCode = paddr == CURRENT_CODE_OFFSET;
	wire hitStatus = paddr == STATUS_OFFSET;
	wire mapped = hitCtrl || hitCode || hitStatus;
	assign pready = accessPhase;
	assign pslverr = accessPhase && !mapped;

	// Register writes land at the access edge only.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			driveCtrl <= DRIVE_CTRL_RESET;
			codeA <= CURRENT_CODE_RESET;
			codeB <= CURRENT_CODE_RESET;
		end else if (accessPhase && pwrite) begin
			if (hitCtrl) begin
				driveCtrl <= pwdata[5:0];
			end else if (hitCode) begin
				codeA <= pwdata[4:0];
				codeB <= pwdata[12:8];
			end
		end
	end

	// Read data is captured in the setup cycle so that it comes from a
	// flop yet is valid for the whole access phase.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (setupPhase) begin
			if (hitCtrl) begin
				prdata <= {26'h0, driveCtrl};
			end else if (hitCode) begin
				prdata <= {19'h0, codeB, 3'h0, codeA};
			end else if (hitStatus) begin
				prdata <= {16'h0, stateB, stateA, 3'h0, sleepSync, awake,
					indexerMode};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	property p_schemeHold;
		@(posedge clk) disable iff (!rst_b)
		(indexerMode != $past(indexerMode)) |-> $past(latchNow);
	endproperty
	a_schemeHold: assert property (p_schemeHold)
		else $error("Scheme changed outside reset or sleep exit.");

	property p_schemeDefault;
		@(posedge clk) disable iff (!rst_b)
		!started |-> !indexerMode;
	endproperty
	a_schemeDefault: assert property (p_schemeDefault)
		else $error("Scheme not low before first latch.");

	property p_schemeFollow;
		@(posedge clk) disable iff (!rst_b)
		latchNow |=> indexerMode == $past(schemeSync);
	endproperty
	a_schemeFollow: assert property (p_schemeFollow)
		else $error("Latched scheme does not match the pin.");

	property p_sharedDecay;
		@(posedge clk) disable iff (!rst_b)
		indexerMode |-> cmdB.level == cmdA.level;
	endproperty
	a_sharedDecay: assert property (p_sharedDecay)
		else $error("Bridge B decay not taken from bridge A.");

	property p_period;
		@(posedge clk) disable iff (!rst_b)
		pwmStart |=> !pwmStart [*8] ##1 (pwmCount == 12'h009);
	endproperty
	a_period: assert property (p_period)
		else $error("PWM counter does not run from zero.");

	property p_scaleFloor;
		@(posedge clk) disable iff (!rst_b)
		indexerMode && $stable(indexerMode) |=>
			bridgeAScale >= DAC_MIN_CODE && bridgeAScale == $past(
				scale_of(indexerMode, codeA));
	endproperty
	a_scaleFloor: assert property (p_scaleFloor)
		else $error("Indexer scale below floor or stale.");

	property p_shortBlank;
		@(posedge clk) disable iff (!rst_b)
		(indexerMode && codeA > DAC_LOW_CODE_MAX) |-> !cmdA.shortBlank;
	endproperty
	a_shortBlank: assert property (p_shortBlank)
		else $error("Short blanking at high current code.");
endmodule // motor_bridge_current_chopper

// >>> winding_model.sv
/*
 * Winding and sense model for one bridge: the current rises while the
 * bridge drives and falls slowly while it recirculates.
 * Assumes the chopper's gate pattern and the direction the bench set.
 */
`timescale 1ns/1ps
module winding_model
	import motor_chop_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire bridge_gate_t gates,
	input  wire logic         dir,
	input  wire logic [11:0]  tripLevel,
	output logic              trip,
	output logic              zero
);
	logic [11:0] amps;
	logic [2:0]  tick;
	wire         driving;
	wire         decaying;

	// Recirculation is eight times slower than the rise, so a 75 percent
	// fast share still ends before the winding empties.
	assign driving = dir ? gates.hs1 & gates.ls2 : gates.hs2 & gates.ls1;
	assign decaying = !driving && (gates != 4'h0);
	assign trip = amps >= tripLevel;
	assign zero = amps == 12'h000;

	// The level saturates so that slow periods cannot pile it up.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			amps <= 12'h000;
			tick <= 3'h0;
		end else begin
			tick <= tick + 3'h1;
			if (driving && amps < 12'h0FA)
				amps <= amps + 12'h001;
			else if (decaying && tick == 3'h7 && amps != 12'h000)
				amps <= amps - 12'h001;
		end
	end
endmodule // winding_model

// >>> motor_bridge_current_chopper_test.sv
/*
 * Self-checking bench for the two-bridge chopper: wake, APB registers,
 * scheme latch, every decay level, blanking, period and enable-low.
 * Assumes a winding model on bridge A; bridge B stays disabled.
 */
`timescale 1ns/1ps
module motor_bridge_current_chopper_test
	import motor_chop_pkg::*;
;
	logic         clk, rst_b, psel, penable, pwrite, scheme, sleepN, stepHigh;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, q, r;
	logic [1:0]   dir, en, refLow;
	logic [2:0]   decA, decB;
	logic         e;
	wire          pready, pslverr, idx, awake, tripA, zeroA;
	wire  [31:0]  prdata;
	wire  [4:0]   scaleA, scaleB;
	bridge_gate_t gA, gB;
	int           failures, compares, n, d, f, t, lv[$], sh[$];

	motor_bridge_current_chopper #(.WAKE_CYCLES(50)) i_dut (.clk(clk),
		.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .controlSchemeSelect(scheme),
		.sleep_request_n(sleepN), .bridge_direction(dir),
		.bridge_drive_enable(en), .step_mode_high_select(stepHigh),
		.bridge_sense_input({1'b0, tripA}), .zeroCurrentDetect({1'b0, zeroA}),
		.bridge_a_decay_select(decA), .bridge_b_decay_select(decB),
		.referenceLow(refLow), .bridgeAScale(scaleA), .bridgeBScale(scaleB),
		.bridgeAGates(gA), .bridgeBGates(gB), .indexerMode(idx),
		.awake(awake));
	winding_model i_wind (.clk(clk), .rst_b(rst_b), .gates(gA),
		.dir(dir[0]), .tripLevel(12'h00A), .trip(tripA), .zero(zeroA));

	// Free-running core clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task conclude;
		if (failures == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task check(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// Pass when got lies in ex..ex+tol; sync latency makes it inexact.
	task near(input string nm, input int ex, input int got, input int tol);
		check(nm, ex, (got >= ex && got <= ex + tol) ? ex : got);
	endtask

	// Count cycles while gate pattern A equals (same) or differs from pat.
	task run(input logic [3:0] pat, input bit same, output int c);
		c = 0;
		while (((gA === pat) == same) && c < 3000) begin
			@(posedge clk);
			#1;
			c++;
		end
		if (c == 3000) begin
			failures++;
			conclude();
		end
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 50) begin
			failures++;
			conclude();
		end
	endtask

	// Exit sleep and wait out the wake time before any stepping.
	task wake;
		@(posedge clk);
		sleepN <= 1'b1;
		n = 0;
		while (awake !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		near("wake", 50, n, 4);
	endtask

	initial begin
		{psel, penable, pwrite, scheme, sleepN, stepHigh} = 6'h00;
		{paddr, pwdata, dir, en, refLow, decA, decB} = '0;
		failures = 0;
		compares = 0;
		rst_b = 1'b0;
		r = $urandom(32'h8e258f6f);
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		check("gates", 4'h0, gA);
		check("scale", 5'h1F, scaleA);
		check("scheme", 1'b0, idx);
		check("awake", 1'b0, awake);
		wake();
		// Random current codes read back in their own fields.
		repeat (3) begin
			r = $urandom;
			apb(1'b1, CURRENT_CODE_OFFSET, r);
			apb(1'b0, CURRENT_CODE_OFFSET, 32'h0);
			check("code", {19'h0, r[12:8], 3'h0, r[4:0]}, q);
		end
		apb(1'b1, STATUS_OFFSET, 32'hFFFFFFFF);
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check("status", 2'h2, q[1:0]);
		apb(1'b0, 8'h0C, 32'h0);
		check("slverr", 1'b1, e);
		check("unmapped", 32'h0000_0000, q);
		@(posedge clk);
		scheme <= 1'b1;
		repeat (6) @(posedge clk);
		check("scheme", 1'b0, idx);
		dir <= 2'b01;
		en <= 2'b01;
		lv = '{1, 2, 3, 4, 0, 0};
		sh = '{0, 0, 0, 0, 0, 1};
		// Each level: skip one period, then time drive, fast and the rest.
		foreach (lv[i]) begin
			decA <= 3'(lv[i]);
			refLow <= {1'b0, 1'(sh[i])};
			run(4'h9, 0, n);
			run(4'h9, 1, n);
			run(4'h9, 0, n);
			run(4'h9, 1, d);
			near("blank", sh[i] ? BLANK_SHORT_CYC : BLANK_LONG_CYC, d, 3);
			run(4'h6, 1, f);
			if (lv[i] != 4) near("fast", lv[i] * PWM_PERIOD_CYC / 4, f, 2);
			check("decay", lv[i] == 4 ? 4'h0 : 4'h5, gA);
			run(4'h9, 0, t);
			check("period", PWM_PERIOD_CYC, d + f + t);
		end
		@(posedge clk);
		en <= 2'b00;
		run(4'h5, 0, n);
		near("brake", 0, n, 5);
		check("brakeB", 4'h5, gB);
		@(posedge clk);
		stepHigh <= 1'b1;
		run(4'h0, 0, n);
		near("float", 0, n, 5);
		check("floatB", 4'h0, gB);
		@(posedge clk);
		sleepN <= 1'b0;
		repeat (5) @(posedge clk);
		wake();
		check("scheme", 1'b1, idx);
		apb(1'b1, CURRENT_CODE_OFFSET, 32'h0);
		repeat (3) @(posedge clk);
		check("floor", DAC_MIN_CODE, scaleA);
		check("floorB", DAC_MIN_CODE, scaleB);
		// Indexer with code 0: short blanking; first with the rising flag
		// set (slow only), then without it (half the period fast).
		decA <= 3'h2;
		decB <= 3'h4;
		apb(1'b1, DRIVE_CTRL_OFFSET, 32'h0000_0015);
		for (int k = 0; k < 2; k++) begin
			run(4'h9, 0, n);
			run(4'h9, 1, n);
			run(4'h9, 0, n);
			run(4'h9, 1, d);
			near("idxBlank", BLANK_SHORT_CYC, d, 3);
			run(4'h6, 1, f);
			near("idxFast", k == 0 ? 0 : 2 * PWM_PERIOD_CYC / 4, f, 2);
			check("idxDecay", 4'h5, gA);
			if (k == 0) apb(1'b1, DRIVE_CTRL_OFFSET, 32'h0000_0005);
		end
		conclude();
	end
endmodule // motor_bridge_current_chopper_test
